// ==== bench/ppp_bus_model.sv ====
// Purpose: primary bus partner, target for bridge masters and initiator
// Assumes: one word per access; strobes pulled up when nobody drives
// Notes: released data lines show the inverse of their last level
module ppp_bus_model (
  // clock
  input wire logic clk,
  // bridge drives
  input wire ppp_pkg::ppp_word_t ad_o,
  input wire logic ad_oe,
  input wire ppp_pkg::ppp_be_t cbe_o,
  input wire logic cbe_oe,
  input wire logic par_o,
  input wire logic par_oe,
  input wire logic frame_o,
  input wire logic frame_oe,
  input wire logic irdy_o,
  input wire logic irdy_oe,
  input wire logic trdy_o,
  input wire logic trdy_oe,
  // target answer
  input wire logic [1:0] wait_n,
  input wire ppp_pkg::ppp_word_t rd_word,
  // resolved bus
  output ppp_pkg::ppp_word_t ad_w,
  output ppp_pkg::ppp_be_t cbe_w,
  output logic par_w,
  output logic frame_w,
  output logic irdy_w,
  output logic trdy_w
);
  timeunit 1ns;
  timeprecision 1ps;
  ppp_pkg::ppp_word_t m_ad, ad_q;
  ppp_pkg::ppp_be_t m_cbe, cbe_q;
  logic m_ad_oe, m_cbe_oe, m_par, m_par_oe, m_frame, m_frame_oe;
  logic m_irdy, m_irdy_oe, m_trdy, m_trdy_oe, par_q, fr_q, hit, rd;

  initial begin
    {m_ad_oe, m_cbe_oe, m_par_oe, m_frame_oe, m_irdy_oe, m_trdy_oe} = '0;
    {m_par, m_frame, m_irdy, m_trdy, fr_q} = '1;
    {m_ad, m_cbe, ad_q, cbe_q, par_q} = '0;
  end

  // =====================================================================
  // wire levels
  assign ad_w = ad_oe ? ad_o : (m_ad_oe ? m_ad : ~ad_q);
  assign cbe_w = cbe_oe ? cbe_o : (m_cbe_oe ? m_cbe : ~cbe_q);
  assign par_w = par_oe ? par_o : (m_par_oe ? m_par : ~par_q);
  assign frame_w = frame_oe ? frame_o : (m_frame_oe ? m_frame : 1'b1);
  assign irdy_w = irdy_oe ? irdy_o : (m_irdy_oe ? m_irdy : 1'b1);
  assign trdy_w = trdy_oe ? trdy_o : (m_trdy_oe ? m_trdy : 1'b1);
  always @(posedge clk) begin
    ad_q <= ad_w;
    cbe_q <= cbe_w;
    par_q <= par_w;
  end

  // =====================================================================
  // target for bridge accesses
  initial forever begin
    @(posedge clk);
    hit = frame_oe === 1'b1 && frame_w === 1'b0 && fr_q === 1'b1;
    fr_q = frame_w;
    if (hit) begin
      rd = ~cbe_w[0];
      @(negedge clk);
      {m_trdy_oe, m_trdy} = 2'b11;
      repeat (wait_n) @(negedge clk);
      @(negedge clk);
      m_trdy = 1'b0;
      m_ad_oe = rd;
      m_ad = rd_word;
      do @(posedge clk); while (irdy_w !== 1'b0);
      m_par = ^{rd_word, cbe_w};
      @(negedge clk);
      {m_trdy, m_ad_oe, m_par_oe} = {2'b10, rd};
      @(negedge clk);
      {m_trdy_oe, m_par_oe} = 2'b00;
    end
  end

  // =====================================================================
  // initiator, one word
  task automatic ext_xfer(input logic rd, input ppp_pkg::ppp_word_t addr,
    input ppp_pkg::ppp_word_t data, input ppp_pkg::ppp_be_t be,
    input logic bad);
    logic [3:0] cmd;
    cmd = rd ? 4'h6 : 4'h7;
    @(negedge clk);
    {m_frame_oe, m_frame, m_irdy_oe, m_irdy, m_ad_oe, m_cbe_oe} = 6'h2F;
    m_ad = addr;
    m_cbe = cmd;
    @(negedge clk);
    {m_par_oe, m_ad_oe} = {1'b1, !rd};
    m_ad = data;
    m_cbe = be;
    m_par = ^{addr, cmd};
    @(negedge clk);
    m_par_oe = !rd;
    m_par = ^{data, be} ^ bad;
    repeat (2 * wait_n) @(negedge clk);
    {m_frame, m_irdy} = 2'b10;
    do @(posedge clk); while (trdy_w !== 1'b0);
    @(negedge clk);
    {m_irdy, m_frame_oe, m_ad_oe} = 3'b100;
    @(negedge clk);
    {m_irdy_oe, m_cbe_oe, m_par_oe} = 3'b000;
  endtask : ext_xfer
endmodule : ppp_bus_model

// ==== bench/tb.sv ====
// Purpose: self-checking bench of the primary port
// Assumes: partner model resolves all bus wires
// Notes: inputs change at the falling edge
`include "ppp_defines.svh"
`define CHK(a, e) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    error_cnt++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ppp_pkg::ppp_word_t ad_w, ad_o, exp_addr, exp_wd, exp_rd, mst_rdata;
  ppp_pkg::ppp_word_t tgt_wdata, x_ad;
  ppp_pkg::ppp_be_t cbe_w, cbe_o, exp_be, exp_cmd, tgt_wbe, x_cbe;
  logic par_w, frame_w, irdy_w, trdy_w, ad_oe, cbe_oe, par_o, par_oe;
  logic frame_o, frame_oe, irdy_o, irdy_oe, trdy_o, trdy_oe, par_err;
  logic gnt_n, mst_req, mst_write, mst_busy, mst_wvalid, mst_wlast;
  logic mst_wready, mst_rvalid, tgt_sel, tgt_read, tgt_rvalid, tgt_rready;
  logic tgt_take, rdop, p_ad_oe, p_fo, p_foe, p_io, p_ioe, p_to, p_toe;
  logic p_gnt, p_fw;
  logic x_hit = 1'b0;
  logic [1:0] wait_n;
  logic [31:0] seed = 32'h7B0D;
  int error_cnt = 0;
  int num_checks = 0;
  int perr_n = 0;
  int perr_exp = 0;
  int take_n = 0;
  int rv_n = 0;

  always #4 clk = ~clk;

  ppp_port dut_u (
    .CLK_SYS(clk), .RSTN(rst_n),
    .PRIMARY_ADDR_DATA_I(ad_w), .PRIMARY_ADDR_DATA_O(ad_o),
    .PRIMARY_ADDR_DATA_OE(ad_oe), .PRIMARY_COMMAND_BYTE_ENABLE_I(cbe_w),
    .PRIMARY_COMMAND_BYTE_ENABLE_O(cbe_o),
    .PRIMARY_COMMAND_BYTE_ENABLE_OE(cbe_oe),
    .PRIMARY_PARITY_LINE_I(par_w), .PRIMARY_PARITY_LINE_O(par_o),
    .PRIMARY_PARITY_LINE_OE(par_oe), .PRIMARY_FRAME_N_I(frame_w),
    .PRIMARY_FRAME_N_O(frame_o), .PRIMARY_FRAME_N_OE(frame_oe),
    .PRIMARY_INITIATOR_READY_N_I(irdy_w),
    .PRIMARY_INITIATOR_READY_N_O(irdy_o),
    .PRIMARY_INITIATOR_READY_N_OE(irdy_oe),
    .PRIMARY_TARGET_READY_N_I(trdy_w), .PRIMARY_TARGET_READY_N_O(trdy_o),
    .PRIMARY_TARGET_READY_N_OE(trdy_oe), .PRIMARY_GRANT_N(gnt_n),
    .MST_REQ(mst_req), .MST_WRITE(mst_write), .MST_CMD(exp_cmd),
    .MST_ADDR(exp_addr), .MST_BUSY(mst_busy), .MST_WVALID(mst_wvalid),
    .MST_WDATA(exp_wd), .MST_BE(exp_be), .MST_WLAST(mst_wlast),
    .MST_WREADY(mst_wready), .MST_RVALID(mst_rvalid),
    .MST_RDATA(mst_rdata), .TGT_SEL(tgt_sel), .TGT_READ(tgt_read),
    .TGT_RVALID(tgt_rvalid), .TGT_RDATA(exp_rd), .TGT_RREADY(tgt_rready),
    .TGT_TAKE(tgt_take), .TGT_WDATA(tgt_wdata), .TGT_WBE(tgt_wbe),
    .PAR_ERR(par_err)
  );

  ppp_bus_model bus_u (
    .clk(clk), .ad_o(ad_o), .ad_oe(ad_oe), .cbe_o(cbe_o), .cbe_oe(cbe_oe),
    .par_o(par_o), .par_oe(par_oe), .frame_o(frame_o), .frame_oe(frame_oe),
    .irdy_o(irdy_o), .irdy_oe(irdy_oe), .trdy_o(trdy_o), .trdy_oe(trdy_oe),
    .wait_n(wait_n), .rd_word(exp_rd), .ad_w(ad_w), .cbe_w(cbe_w),
    .par_w(par_w), .frame_w(frame_w), .irdy_w(irdy_w), .trdy_w(trdy_w)
  );

  // =====================================================================
  // bus monitor, sampled after each rising edge has settled
  always @(posedge clk) begin
    #2;
    if (rst_n) begin
      if (p_foe && !frame_oe) `CHK(p_fo, 1'b1)
      if (p_ioe && !irdy_oe) `CHK(p_io, 1'b1)
      if (p_toe && !trdy_oe) `CHK(p_to, 1'b1)
      if (frame_oe && !p_foe) `CHK(p_gnt, 1'b0)
      if (frame_oe && frame_o && p_foe && !p_fo) `CHK(irdy_o, 1'b0)
      `CHK(par_oe, p_ad_oe)
      if (par_oe) `CHK(par_o, ^{x_ad, x_cbe})
      if (!frame_w && p_fw) begin
        `CHK(ad_w, exp_addr)
        `CHK(cbe_w, exp_cmd)
      end
      if (x_hit) begin
        `CHK(x_ad, rdop ? exp_rd : exp_wd)
        `CHK(x_cbe, exp_be)
      end
      if (mst_rvalid) begin
        rv_n++;
        `CHK(mst_rdata, exp_rd)
      end
      if (tgt_take) begin
        take_n++;
        if (!rdop) `CHK({tgt_wdata, tgt_wbe}, {exp_wd, exp_be})
      end
      if (par_err) perr_n++;
    end
    {p_ad_oe, p_fo, p_foe} = {ad_oe, frame_o, frame_oe};
    {p_io, p_ioe, p_to, p_toe} = {irdy_o, irdy_oe, trdy_o, trdy_oe};
    {p_gnt, p_fw} = {gnt_n, frame_w};
  end

  // bus levels that stand at the coming rising edge
  always @(negedge clk) begin
    #2;
    x_hit = (irdy_w === 1'b0) && (trdy_w === 1'b0);
    {x_ad, x_cbe} = {ad_w, cbe_w};
  end

  // =====================================================================
  // stimulus tasks
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic new_vals(input logic rd);
    logic [31:0] r;
    r = xs();
    exp_addr = xs();
    exp_wd = xs();
    exp_rd = xs();
    exp_be = r[3:0];
    wait_n = r[5:4];
    exp_cmd = rd ? 4'h6 : 4'h7;
    rdop = rd;
  endtask : new_vals

  task automatic mst_acc(input logic rd);
    int n;
    new_vals(rd);
    rv_n = 0;
    n = 0;
    @(negedge clk);
    {mst_req, mst_write, mst_wvalid} = {1'b1, !rd, 1'b1};
    do begin @(negedge clk); n++; end while (mst_busy !== 1'b1 && n < 50);
    mst_req = 1'b0;
    while (mst_wready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    @(negedge clk);
    mst_wvalid = 1'b0;
    while (mst_busy === 1'b1 && n < 300) begin @(negedge clk); n++; end
    `CHK(rv_n, rd ? 1 : 0)
  endtask : mst_acc

  task automatic tgt_acc(input logic rd, input logic bad);
    int n;
    new_vals(rd);
    perr_exp += bad;
    n = 0;
    fork
      bus_u.ext_xfer(rd, exp_addr, exp_wd, exp_be, bad);
      begin
        repeat (2) @(negedge clk);
        {tgt_sel, tgt_read, tgt_rvalid} = {1'b1, rd, rd};
        while (rd && tgt_rready !== 1'b1 && n < 50) begin
          @(negedge clk);
          n++;
        end
        @(negedge clk);
        tgt_rvalid = 1'b0;
        while (tgt_take !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        {tgt_sel, tgt_read} = 2'b00;
      end
    join
    repeat (3) @(negedge clk);
    `CHK(perr_n, perr_exp)
  endtask : tgt_acc

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // =====================================================================
  // main sequence and watchdog
  initial begin
    {gnt_n, mst_req, mst_write, mst_wvalid, tgt_sel, tgt_read} = '0;
    tgt_rvalid = 1'b0;
    mst_wlast = 1'b1;
    new_vals(1'b0);
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({ad_oe, cbe_oe, par_oe}, 3'b111)
    `CHK({ad_o, cbe_o}, {`PPP_PARK_AD, `PPP_PARK_BE})
    for (int i = 0; i < 4; i++) begin
      mst_acc(1'b0);
      mst_acc(1'b1);
      gnt_n = 1'b1;
      repeat (3) @(negedge clk);
      tgt_acc(1'b0, 1'b0);
      tgt_acc(1'b0, 1'b1);
      tgt_acc(1'b1, 1'b0);
      gnt_n = 1'b0;
      repeat (3) @(negedge clk);
    end
    `CHK(take_n, 12)
    tally_and_finish();
  end

  // a full run needs under 300 cycles; the limit of 7000 cycles allows over twenty times that
  initial begin
    #56000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb

// ==== core/ppp_defines.svh ====
// Purpose: constants of the primary address/data/parity port
// Assumes: the primary bus clock is CLK_SYS, so bus pins need no synchroniser
// Notes: included by the port and parity modules
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH

// =====================================================================
// widths and levels
`define PPP_AD_W 32
`define PPP_BE_W 4
`define PPP_ON_N 1'b0
`define PPP_OFF_N 1'b1

// =====================================================================
// reset and parking values
`define PPP_PARK_AD 32'h0000_0000
`define PPP_PARK_BE 4'h0
`define PPP_RST_AD 32'h0000_0000
`define PPP_RST_BE 4'h0

`endif

// ==== core/ppp_par_if.sv ====
// Purpose: carrier between the port and its parity unit
// Assumes: one clock
// Notes: port drives values, parity unit returns pin and error
interface ppp_par_if;
  ppp_pkg::ppp_word_t ad_drv;
  ppp_pkg::ppp_be_t cbe_drv;
  logic drive;
  ppp_pkg::ppp_word_t ad_in;
  ppp_pkg::ppp_be_t cbe_in;
  logic par_in;
  logic chk;
  logic par;
  logic par_oe;
  logic err;
  modport port (output ad_drv, cbe_drv, drive, ad_in, cbe_in, par_in, chk,
    input par, par_oe, err);
  modport gen (input ad_drv, cbe_drv, drive, ad_in, cbe_in, par_in, chk,
    output par, par_oe, err);
endinterface : ppp_par_if

// ==== core/ppp_parity.sv ====
// Purpose: parity driver and checker of the primary port
// Assumes: drive marks the clocks in which the port drives data lines
// Notes: par and par_oe lag the data lines by one clock
`include "ppp_defines.svh"
module ppp_parity (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // port side
  ppp_par_if.gen pif
);

  function automatic logic ppp_even(input ppp_pkg::ppp_word_t ad,
    input ppp_pkg::ppp_be_t be);
    ppp_even = ^{ad, be};
  endfunction : ppp_even

  logic chk_q;
  ppp_pkg::ppp_word_t ad_s_q;
  ppp_pkg::ppp_be_t cbe_s_q;

  // =====================================================================
  // driven parity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pif.par <= 1'b0;
      pif.par_oe <= 1'b0;
    end else begin
      pif.par <= ppp_even(pif.ad_drv, pif.cbe_drv);
      pif.par_oe <= pif.drive;
    end
  end

  // =====================================================================
  // received parity check
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_q <= 1'b0;
      ad_s_q <= `PPP_RST_AD;
      cbe_s_q <= `PPP_RST_BE;
      pif.err <= 1'b0;
    end else begin
      chk_q <= pif.chk;
      ad_s_q <= pif.ad_in;
      cbe_s_q <= pif.cbe_in;
      pif.err <= chk_q && (ppp_even(ad_s_q, cbe_s_q) != pif.par_in);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  par_even_a: assert property (pif.drive |=>
    ((^{$past(pif.ad_drv), $past(pif.cbe_drv), pif.par}) == 1'b0))
    else $error("driven parity not even");
  par_rel_a: assert property ($fell(pif.drive) |-> pif.par_oe ##1
    !pif.par_oe)
    else $error("parity not released one clock after data");
  par_chk_a: assert property (pif.chk |=> ##1 (pif.err ==
    (^{$past(pif.ad_in, 2), $past(pif.cbe_in, 2), $past(pif.par_in)})))
    else $error("parity error flag wrong");

endmodule : ppp_parity

// ==== core/ppp_pkg.sv ====
// Purpose: types of the primary port
// Assumes: widths from ppp_defines.svh
// Notes: none
`include "ppp_defines.svh"
package ppp_pkg;
  typedef logic [`PPP_AD_W-1:0] ppp_word_t;
  typedef logic [`PPP_BE_W-1:0] ppp_be_t;
  typedef enum logic [1:0] {
    PPP_M_IDLE = 2'b00,
    PPP_M_ADDR = 2'b01,
    PPP_M_DATA = 2'b10,
    PPP_M_REL = 2'b11
  } ppp_mst_state_t;
endpackage : ppp_pkg

// ==== core/ppp_port.sv ====
// Purpose: primary address/data, command and parity port of the bridge
// Assumes: outer logic decodes target hits and handles select/stop
// Notes: master write words and target read data use a valid/ready handshake; master read and target write words are only flagged by MST_RVALID and TGT_TAKE
`include "ppp_defines.svh"
module ppp_port (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // primary address/data lines
  input wire ppp_pkg::ppp_word_t PRIMARY_ADDR_DATA_I,
  output ppp_pkg::ppp_word_t PRIMARY_ADDR_DATA_O,
  output logic PRIMARY_ADDR_DATA_OE,
  // primary command/byte enable lines
  input wire ppp_pkg::ppp_be_t PRIMARY_COMMAND_BYTE_ENABLE_I,
  output ppp_pkg::ppp_be_t PRIMARY_COMMAND_BYTE_ENABLE_O,
  output logic PRIMARY_COMMAND_BYTE_ENABLE_OE,
  // primary parity line
  input wire logic PRIMARY_PARITY_LINE_I,
  output logic PRIMARY_PARITY_LINE_O,
  output logic PRIMARY_PARITY_LINE_OE,
  // primary strobes and grant
  input wire logic PRIMARY_FRAME_N_I,
  output logic PRIMARY_FRAME_N_O,
  output logic PRIMARY_FRAME_N_OE,
  input wire logic PRIMARY_INITIATOR_READY_N_I,
  output logic PRIMARY_INITIATOR_READY_N_O,
  output logic PRIMARY_INITIATOR_READY_N_OE,
  input wire logic PRIMARY_TARGET_READY_N_I,
  output logic PRIMARY_TARGET_READY_N_O,
  output logic PRIMARY_TARGET_READY_N_OE,
  input wire logic PRIMARY_GRANT_N,
  // master request
  input wire logic MST_REQ,
  input wire logic MST_WRITE,
  input wire ppp_pkg::ppp_be_t MST_CMD,
  input wire ppp_pkg::ppp_word_t MST_ADDR,
  output logic MST_BUSY,
  // master data words
  input wire logic MST_WVALID,
  input wire ppp_pkg::ppp_word_t MST_WDATA,
  input wire ppp_pkg::ppp_be_t MST_BE,
  input wire logic MST_WLAST,
  output logic MST_WREADY,
  output logic MST_RVALID,
  output ppp_pkg::ppp_word_t MST_RDATA,
  // target side
  input wire logic TGT_SEL,
  input wire logic TGT_READ,
  input wire logic TGT_RVALID,
  input wire ppp_pkg::ppp_word_t TGT_RDATA,
  output logic TGT_RREADY,
  output logic TGT_TAKE,
  output ppp_pkg::ppp_word_t TGT_WDATA,
  output ppp_pkg::ppp_be_t TGT_WBE,
  // status
  output logic PAR_ERR
);

  ppp_par_if pif ();

  ppp_pkg::ppp_mst_state_t state_q;
  logic last_q;
  logic wr_q;
  logic frame_in_q;
  logic tgt_have_q;
  logic tgt_rel_q;
  logic bus_idle;
  logic start;
  logic park;
  logic w_take;
  logic m_xfer;
  logic t_xfer;
  logic tgt_rd_take;
  logic tgt_busy;

  // =====================================================================
  // bus conditions
  assign bus_idle = PRIMARY_FRAME_N_I && PRIMARY_INITIATOR_READY_N_I;
  assign tgt_busy = TGT_SEL || PRIMARY_TARGET_READY_N_OE;
  assign start = (state_q == ppp_pkg::PPP_M_IDLE) && MST_REQ && bus_idle &&
    !PRIMARY_GRANT_N && !tgt_busy;
  assign park = (state_q == ppp_pkg::PPP_M_IDLE) && !MST_REQ && bus_idle &&
    !PRIMARY_GRANT_N && !tgt_busy;
  assign w_take = MST_WVALID && MST_WREADY;
  assign m_xfer = (state_q == ppp_pkg::PPP_M_DATA) &&
    !PRIMARY_INITIATOR_READY_N_O && !PRIMARY_TARGET_READY_N_I;
  assign t_xfer = PRIMARY_TARGET_READY_N_OE && !PRIMARY_TARGET_READY_N_O &&
    !PRIMARY_INITIATOR_READY_N_I;
  assign tgt_rd_take = TGT_RVALID && TGT_RREADY;

  // =====================================================================
  // master sequencer
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ppp_pkg::PPP_M_IDLE;
      wr_q <= 1'b0;
      last_q <= 1'b0;
      MST_BUSY <= 1'b0;
      MST_WREADY <= 1'b0;
    end else begin
      if (w_take) begin
        MST_WREADY <= 1'b0;
        last_q <= MST_WLAST;
      end
      case (state_q)
        ppp_pkg::PPP_M_IDLE: begin
          if (start) begin
            state_q <= ppp_pkg::PPP_M_ADDR;
            wr_q <= MST_WRITE;
            MST_BUSY <= 1'b1;
            MST_WREADY <= 1'b1;
          end
        end
        ppp_pkg::PPP_M_ADDR: state_q <= ppp_pkg::PPP_M_DATA;
        ppp_pkg::PPP_M_DATA: begin
          if (m_xfer && last_q) begin
            state_q <= ppp_pkg::PPP_M_REL;
          end else if (m_xfer) begin
            MST_WREADY <= 1'b1;
          end
        end
        ppp_pkg::PPP_M_REL: begin
          state_q <= ppp_pkg::PPP_M_IDLE;
          MST_BUSY <= 1'b0;
        end
        default: state_q <= ppp_pkg::PPP_M_IDLE;
      endcase
    end
  end

  // =====================================================================
  // frame and initiator ready
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PRIMARY_FRAME_N_O <= `PPP_OFF_N;
      PRIMARY_FRAME_N_OE <= 1'b0;
      PRIMARY_INITIATOR_READY_N_O <= `PPP_OFF_N;
      PRIMARY_INITIATOR_READY_N_OE <= 1'b0;
    end else begin
      if (start) begin
        PRIMARY_FRAME_N_O <= `PPP_ON_N;
        PRIMARY_FRAME_N_OE <= 1'b1;
        PRIMARY_INITIATOR_READY_N_O <= `PPP_OFF_N;
        PRIMARY_INITIATOR_READY_N_OE <= 1'b1;
      end else if (w_take) begin
        PRIMARY_INITIATOR_READY_N_O <= `PPP_ON_N;
        if (MST_WLAST) begin
          PRIMARY_FRAME_N_O <= `PPP_OFF_N;
        end
      end else if (m_xfer) begin
        PRIMARY_INITIATOR_READY_N_O <= `PPP_OFF_N;
        if (last_q) begin
          PRIMARY_FRAME_N_OE <= 1'b0;
        end
      end else if (state_q == ppp_pkg::PPP_M_REL) begin
        PRIMARY_INITIATOR_READY_N_OE <= 1'b0;
      end
    end
  end

  // =====================================================================
  // address/data and command/byte enables
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PRIMARY_ADDR_DATA_O <= `PPP_RST_AD;
      PRIMARY_ADDR_DATA_OE <= 1'b0;
      PRIMARY_COMMAND_BYTE_ENABLE_O <= `PPP_RST_BE;
      PRIMARY_COMMAND_BYTE_ENABLE_OE <= 1'b0;
    end else if (start) begin
      PRIMARY_ADDR_DATA_O <= MST_ADDR;
      PRIMARY_ADDR_DATA_OE <= 1'b1;
      PRIMARY_COMMAND_BYTE_ENABLE_O <= MST_CMD;
      PRIMARY_COMMAND_BYTE_ENABLE_OE <= 1'b1;
    end else if (state_q != ppp_pkg::PPP_M_IDLE) begin
      if (w_take) begin
        PRIMARY_COMMAND_BYTE_ENABLE_O <= MST_BE;
        if (wr_q) begin
          PRIMARY_ADDR_DATA_O <= MST_WDATA;
        end
      end
      if (state_q == ppp_pkg::PPP_M_ADDR) begin
        PRIMARY_ADDR_DATA_OE <= wr_q;
      end
      if (m_xfer && last_q) begin
        PRIMARY_ADDR_DATA_OE <= 1'b0;
      end
      if (state_q == ppp_pkg::PPP_M_REL) begin
        PRIMARY_COMMAND_BYTE_ENABLE_OE <= 1'b0;
      end
    end else if (tgt_busy) begin
      PRIMARY_COMMAND_BYTE_ENABLE_OE <= 1'b0;
      if (tgt_rd_take) begin
        PRIMARY_ADDR_DATA_O <= TGT_RDATA;
        PRIMARY_ADDR_DATA_OE <= 1'b1;
      end else if ((t_xfer && PRIMARY_FRAME_N_I) || !TGT_READ) begin
        PRIMARY_ADDR_DATA_OE <= 1'b0;
      end
    end else begin
      PRIMARY_ADDR_DATA_O <= `PPP_PARK_AD;
      PRIMARY_ADDR_DATA_OE <= park;
      PRIMARY_COMMAND_BYTE_ENABLE_O <= `PPP_PARK_BE;
      PRIMARY_COMMAND_BYTE_ENABLE_OE <= park;
    end
  end

  // =====================================================================
  // master read data
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      MST_RVALID <= 1'b0;
      MST_RDATA <= `PPP_RST_AD;
    end else begin
      MST_RVALID <= m_xfer && !wr_q;
      if (m_xfer && !wr_q) begin
        MST_RDATA <= PRIMARY_ADDR_DATA_I;
      end
    end
  end

  // =====================================================================
  // target ready and target data
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PRIMARY_TARGET_READY_N_O <= `PPP_OFF_N;
      PRIMARY_TARGET_READY_N_OE <= 1'b0;
      TGT_RREADY <= 1'b0;
      TGT_TAKE <= 1'b0;
      TGT_WDATA <= `PPP_RST_AD;
      TGT_WBE <= `PPP_RST_BE;
      tgt_have_q <= 1'b0;
      tgt_rel_q <= 1'b0;
    end else begin
      TGT_TAKE <= t_xfer;
      TGT_RREADY <= TGT_SEL && TGT_READ && !tgt_have_q && !tgt_rd_take &&
        !tgt_rel_q;
      if (tgt_rd_take) begin
        tgt_have_q <= 1'b1;
      end else if (t_xfer) begin
        tgt_have_q <= 1'b0;
      end
      if (t_xfer) begin
        TGT_WDATA <= PRIMARY_ADDR_DATA_I;
        TGT_WBE <= PRIMARY_COMMAND_BYTE_ENABLE_I;
        PRIMARY_TARGET_READY_N_O <= `PPP_OFF_N;
        tgt_rel_q <= PRIMARY_FRAME_N_I;
      end else if (tgt_rel_q) begin
        PRIMARY_TARGET_READY_N_OE <= 1'b0;
        tgt_rel_q <= 1'b0;
      end else if (TGT_SEL && PRIMARY_TARGET_READY_N_O &&
          (!TGT_READ || tgt_have_q)) begin
        PRIMARY_TARGET_READY_N_O <= `PPP_ON_N;
        PRIMARY_TARGET_READY_N_OE <= 1'b1;
      end
    end
  end

  // =====================================================================
  // parity unit
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      frame_in_q <= `PPP_OFF_N;
    end else begin
      frame_in_q <= PRIMARY_FRAME_N_I;
    end
  end

  assign pif.ad_drv = PRIMARY_ADDR_DATA_O;
  // as target the initiator owns the command/byte enable lines
  assign pif.cbe_drv = PRIMARY_COMMAND_BYTE_ENABLE_OE ?
    PRIMARY_COMMAND_BYTE_ENABLE_O : PRIMARY_COMMAND_BYTE_ENABLE_I;
  assign pif.drive = PRIMARY_ADDR_DATA_OE;
  assign pif.ad_in = PRIMARY_ADDR_DATA_I;
  assign pif.cbe_in = PRIMARY_COMMAND_BYTE_ENABLE_I;
  assign pif.par_in = PRIMARY_PARITY_LINE_I;
  assign pif.chk = (!PRIMARY_FRAME_N_I && frame_in_q &&
    !PRIMARY_FRAME_N_OE) || (t_xfer && !TGT_READ);
  assign PRIMARY_PARITY_LINE_O = pif.par;
  assign PRIMARY_PARITY_LINE_OE = pif.par_oe;
  assign PAR_ERR = pif.err;

  ppp_parity u_parity (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .pif(pif.gen)
  );

  // =====================================================================
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  sequence park_drive_s;
    PRIMARY_ADDR_DATA_OE && PRIMARY_COMMAND_BYTE_ENABLE_OE &&
      (PRIMARY_ADDR_DATA_O == `PPP_PARK_AD) ##1 PRIMARY_PARITY_LINE_OE;
  endsequence

  sequence master_end_s;
    PRIMARY_INITIATOR_READY_N_O && PRIMARY_INITIATOR_READY_N_OE &&
      !PRIMARY_FRAME_N_OE ##1 !PRIMARY_INITIATOR_READY_N_OE;
  endsequence

  strobe_high_a: assert property ($fell(PRIMARY_FRAME_N_OE) ||
    $fell(PRIMARY_TARGET_READY_N_OE) |->
    ($past(PRIMARY_FRAME_N_O) && $past(PRIMARY_TARGET_READY_N_O)))
    else $error("strobe released without high clock");
  master_end_a: assert property (m_xfer && last_q |=> master_end_s)
    else $error("master release order wrong");
  addr_phase_a: assert property (start |=> !PRIMARY_FRAME_N_O &&
    (PRIMARY_ADDR_DATA_O == $past(MST_ADDR)) &&
    (PRIMARY_COMMAND_BYTE_ENABLE_O == $past(MST_CMD)))
    else $error("address phase wrong");
  write_hold_a: assert property (wr_q && !PRIMARY_INITIATOR_READY_N_O &&
    !m_xfer && (state_q == ppp_pkg::PPP_M_DATA) |=>
    $stable(PRIMARY_ADDR_DATA_O) && !PRIMARY_INITIATOR_READY_N_O)
    else $error("write data moved during wait");
  read_drive_a: assert property (TGT_READ && TGT_SEL &&
    !PRIMARY_TARGET_READY_N_O && !t_xfer |=> $stable(PRIMARY_ADDR_DATA_O))
    else $error("read data moved during wait");
  xfer_end_a: assert property (m_xfer |=> PRIMARY_INITIATOR_READY_N_O)
    else $error("initiator ready held after transfer");
  park_a: assert property (park |=> park_drive_s)
    else $error("bus not parked");
  last_frame_a: assert property (w_take && MST_WLAST |=>
    PRIMARY_FRAME_N_O && !PRIMARY_INITIATOR_READY_N_O)
    else $error("frame not ended with last phase");
  grant_a: assert property ($rose(PRIMARY_FRAME_N_OE) |->
    !$past(PRIMARY_GRANT_N))
    else $error("bus driven without grant");
  read_par_a: assert property ($rose(PRIMARY_ADDR_DATA_OE) ##1
    PRIMARY_ADDR_DATA_OE |-> PRIMARY_PARITY_LINE_OE)
    else $error("parity not driven one clock after data");

endmodule : ppp_port
